// [core/vox_codec_serial.sv]
`timescale 1ns/10ps
`include "vox_codec_params.svh"
// Summary of operation
// - Power-down pin low powers codec down
// - Power-down is pin OR register bit
// - Register reset pin low clears registers
// - Tx PCM out MSB first, rising edge
// - Tx PCM in sampled on falling edge
// - Rx PCM out carries decoder result
// - Rx PCM in captured on falling edge
// - Tx ADPCM out MSB first, rising edge
// - Tx ADPCM open-drain, released in power-down
// - Rx ADPCM in shifted on falling edge
// - Voice detect high when speech present
// - Voice detect readable in status bit 7
// - Threshold chosen by voice bits 6:5
// - Voice flag low substitutes background noise
// - Voice flag pin ORed with bit 3
// - Voice pins work only with bit 7
// - Tone sign outputs individually enabled
module vox_codec_serial #(
    parameter int PCM_W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic reg_reset_n,
    input wire logic codec_powerdown_pin,
    input wire logic shift_clk,
    input wire logic tx_frame_sync,
    input wire logic rx_frame_sync,
    input wire logic tx_pcm_in,
    input wire logic rx_pcm_in,
    input wire logic adpcm_rx_in,
    input wire logic rx_voice_flag_in,
    input wire logic [2:0] tone_sign_in,
    output logic tx_pcm_out,
    output logic rx_pcm_out,
    output logic adpcm_tx_out,
    output logic adpcm_tx_oe,
    output logic tx_voice_detect_out,
    output logic [2:0] tone_sign_outputs,
    output logic codec_powered_down,
    output logic rx_noise_select
);
    // ==========================================================
    // Input synchronisers
    logic [5:0] s1_r, s2_r, s3_r;
    vox_codec_pkg::serial_in_s pin_w;
    assign pin_w = '{shift_clk, tx_frame_sync, rx_frame_sync, tx_pcm_in, rx_pcm_in, adpcm_rx_in};
    logic [1:0] vf_r;
    logic vf_s3_r;
    logic [1:0] rr_r;
    logic rr_s3_r;
    logic sck_lvl_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_r <= 6'h00;
            s2_r <= 6'h00;
            s3_r <= 6'h00;
            vf_r <= 2'h0;
            vf_s3_r <= 1'b0;
            rr_r <= 2'h0;
            rr_s3_r <= 1'b0;
            sck_lvl_r <= 1'b0;
        end else begin
            if (s2_r[5] == s3_r[5]) sck_lvl_r <= s2_r[5];
            s1_r <= pin_w;
            s2_r <= s1_r;
            s3_r <= s2_r;
            vf_r <= {vf_r[0], rx_voice_flag_in};
            vf_s3_r <= vf_r[1];
            rr_r <= {rr_r[0], reg_reset_n};
            rr_s3_r <= rr_r[1];
        end
    end
    vox_codec_pkg::serial_in_s q_w, prev_w;
    assign q_w = s2_r;
    assign prev_w = s3_r;
    // Clock edges once two stages agree on the new level
    wire sck_rise = q_w.shift_clk & prev_w.shift_clk & ~sck_lvl_r;
    wire sck_fall = ~q_w.shift_clk & ~prev_w.shift_clk & sck_lvl_r;
    wire reg_clear = ~rr_r[1] & ~rr_s3_r;
    wire voice_pin = vf_r[1] & vf_s3_r;

    // ==========================================================
    // AHB-Lite slave
    logic [7:0] power_r, mode_r, switch_r, voice_r;
    logic [PCM_W-1:0] tx_sample_r, rx_result_r;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    wire take = hsel & hready & htrans[1];
    wire [7:0] a_w = haddr[7:0];
    wire clr_all = reg_clear;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= take & hwrite;
            wr_addr_r <= a_w;
        end
    end
    wire wr_power = wr_pend_r & (wr_addr_r == `OFS_POWER);
    wire wr_mode = wr_pend_r & (wr_addr_r == `OFS_CODEC_MODE);
    wire wr_switch = wr_pend_r & (wr_addr_r == `OFS_SWITCH);
    wire wr_voice = wr_pend_r & (wr_addr_r == `OFS_VOICE);
    wire wr_sample = wr_pend_r & (wr_addr_r == `OFS_TX_SAMPLE);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            power_r <= `REG_RESET;
            mode_r <= `REG_RESET;
            switch_r <= `REG_RESET;
            voice_r <= `REG_RESET;
            tx_sample_r <= '0;
        end else if (clr_all) begin
            power_r <= `REG_RESET;
            mode_r <= `REG_RESET;
            switch_r <= `REG_RESET;
            voice_r <= `REG_RESET;
            tx_sample_r <= '0;
        end else begin
            if (wr_power) power_r <= hwdata[7:0];
            if (wr_mode) mode_r <= hwdata[7:0];
            if (wr_switch) switch_r <= hwdata[7:0];
            if (wr_voice) voice_r <= hwdata[7:0];
            if (wr_sample) tx_sample_r <= hwdata[PCM_W-1:0];
        end
    end
    logic [7:0] status_w;
    logic [31:0] rd_w;
    always_comb begin
        rd_w = `WORD_RESET;
        unique case (a_w)
            `OFS_POWER: rd_w[7:0] = power_r;
            `OFS_CODEC_MODE: rd_w[7:0] = mode_r;
            `OFS_SWITCH: rd_w[7:0] = switch_r;
            `OFS_VOICE: rd_w[7:0] = voice_r;
            `OFS_STATUS: rd_w[7:0] = status_w;
            `OFS_TX_SAMPLE: rd_w[PCM_W-1:0] = tx_sample_r;
            `OFS_RX_RESULT: rd_w[PCM_W-1:0] = rx_result_r;
            default: rd_w = `WORD_RESET;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) hrdata <= `WORD_RESET;
        else if (take & ~hwrite) hrdata <= rd_w;
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ==========================================================
    // Power-down and word lengths
    wire pdn = ~codec_powerdown_pin | power_r[`BIT_PDN_ALL];
    assign codec_powered_down = pdn;
    vox_codec_pkg::adpcm_rate_e rate_w;
    assign rate_w = vox_codec_pkg::adpcm_rate_e'(mode_r[`BIT_MODE_HI:`BIT_MODE_LO]);
    logic [3:0] adpcm_len_w;
    always_comb begin
        unique case (rate_w)
            vox_codec_pkg::ADPCM_24K: adpcm_len_w = `ADPCM_BITS_24K;
            vox_codec_pkg::ADPCM_16K: adpcm_len_w = `ADPCM_BITS_16K;
            default: adpcm_len_w = `ADPCM_BITS_32K;
        endcase
    end

    // ==========================================================
    // Transmit path
    logic [PCM_W-1:0] tx_sh_r, tx_cap_r, tx_in_r;
    logic [3:0] tx_cnt_r, txi_cnt_r;
    logic [3:0] adpcm_sh_r;
    logic tx_out_r, adpcm_bit_r, tx_armed_r;
    wire [3:0] adpcm_code_w = tx_in_r[PCM_W-1 -: 4];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_sh_r <= '0;
            tx_cnt_r <= 4'h0;
            tx_out_r <= 1'b0;
            adpcm_sh_r <= 4'h0;
            adpcm_bit_r <= 1'b1;
            tx_armed_r <= 1'b0;
        end else if (pdn) begin
            tx_cnt_r <= 4'h0;
            adpcm_bit_r <= 1'b1;
        end else if (sck_rise) begin
            if (q_w.tx_sync) begin
                tx_out_r <= tx_sample_r[PCM_W-1];
                tx_sh_r <= {tx_sample_r[PCM_W-2:0], 1'b0};
                adpcm_bit_r <= adpcm_code_w[3];
                adpcm_sh_r <= {adpcm_code_w[2:0], 1'b0};
                tx_cnt_r <= 4'h1;
            end else if (tx_cnt_r != 4'h0 && tx_cnt_r < `PCM_BITS) begin
                tx_out_r <= tx_sh_r[PCM_W-1];
                tx_sh_r <= {tx_sh_r[PCM_W-2:0], 1'b0};
                adpcm_bit_r <= (tx_cnt_r < adpcm_len_w) ? adpcm_sh_r[3] : 1'b1;
                adpcm_sh_r <= {adpcm_sh_r[2:0], 1'b0};
                tx_cnt_r <= tx_cnt_r + 4'h1;
            end else begin
                adpcm_bit_r <= 1'b1;
                tx_cnt_r <= 4'h0;
            end
            tx_armed_r <= 1'b1;
        end
    end
    // Falling-edge sampling of looped tx PCM
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_cap_r <= '0;
            tx_in_r <= '0;
            txi_cnt_r <= 4'h0;
        end else if (sck_fall & tx_armed_r) begin
            tx_cap_r <= {tx_cap_r[PCM_W-2:0], q_w.tx_pcm};
            if (txi_cnt_r == `PCM_BITS - 4'h1) begin
                tx_in_r <= {tx_cap_r[PCM_W-2:0], q_w.tx_pcm};
                txi_cnt_r <= 4'h0;
            end else if (txi_cnt_r != 4'h0 || q_w.tx_sync) begin
                txi_cnt_r <= txi_cnt_r + 4'h1;
            end
        end
    end
    assign tx_pcm_out = tx_out_r;
    assign adpcm_tx_out = 1'b0;
    assign adpcm_tx_oe = ~pdn & ~adpcm_bit_r;

    // ==========================================================
    // Receive path
    logic [PCM_W-1:0] rx_cap_r, rx_sh_r, rx_word_r;
    logic [3:0] rx_code_r, rx_code_sh_r;
    logic [3:0] rxi_cnt_r, rxo_cnt_r;
    logic rx_out_r;
    wire vox_en = voice_r[`BIT_VOX_EN];
    wire rx_voice = ~vox_en | voice_pin | voice_r[`BIT_VOX_IN];
    assign rx_noise_select = ~rx_voice;
    wire [PCM_W-1:0] noise_w = {{(PCM_W-2){1'b0}}, voice_r[1:0]};
    wire [PCM_W-1:0] decoded_w = rx_voice ? rx_word_r : noise_w;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_cap_r <= '0;
            rx_word_r <= '0;
            rx_code_r <= 4'h0;
            rx_code_sh_r <= 4'h0;
            rxi_cnt_r <= 4'h0;
            rx_result_r <= '0;
        end else if (sck_fall & ~pdn) begin
            rx_cap_r <= {rx_cap_r[PCM_W-2:0], q_w.rx_pcm};
            if (q_w.rx_sync) begin
                rx_code_sh_r <= {3'h0, q_w.adpcm_rx};
                rxi_cnt_r <= 4'h1;
            end else if (rxi_cnt_r != 4'h0) begin
                if (rxi_cnt_r < adpcm_len_w)
                    rx_code_sh_r <= {rx_code_sh_r[2:0], q_w.adpcm_rx};
                if (rxi_cnt_r == adpcm_len_w)
                    rx_code_r <= rx_code_sh_r;
                if (rxi_cnt_r == `PCM_BITS - 4'h1) begin
                    rx_result_r <= {rx_cap_r[PCM_W-2:0], q_w.rx_pcm};
                    rxi_cnt_r <= 4'h0;
                end else begin
                    rxi_cnt_r <= rxi_cnt_r + 4'h1;
                end
            end
            rx_word_r <= {rx_code_r, {(PCM_W-4){1'b0}}};
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_sh_r <= '0;
            rxo_cnt_r <= 4'h0;
            rx_out_r <= 1'b0;
        end else if (sck_rise & ~pdn) begin
            if (q_w.rx_sync) begin
                rx_out_r <= decoded_w[PCM_W-1];
                rx_sh_r <= {decoded_w[PCM_W-2:0], 1'b0};
                rxo_cnt_r <= 4'h1;
            end else if (rxo_cnt_r != 4'h0 && rxo_cnt_r < `PCM_BITS) begin
                rx_out_r <= rx_sh_r[PCM_W-1];
                rx_sh_r <= {rx_sh_r[PCM_W-2:0], 1'b0};
                rxo_cnt_r <= rxo_cnt_r + 4'h1;
            end else begin
                rxo_cnt_r <= 4'h0;
            end
        end
    end
    assign rx_pcm_out = rx_out_r;

    // ==========================================================
    // Voice detect and tone signs
    logic [7:0] thr_w;
    always_comb begin
        unique case (voice_r[`BIT_VOX_LVL_HI:`BIT_VOX_LVL_LO])
            2'h0: thr_w = `VOX_THR_0;
            2'h1: thr_w = `VOX_THR_1;
            2'h2: thr_w = `VOX_THR_2;
            default: thr_w = `VOX_THR_3;
        endcase
    end
    wire [7:0] mag_w = tx_in_r[PCM_W-1] ? ~tx_in_r[7:0] : tx_in_r[7:0];
    logic vox_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) vox_r <= 1'b0;
        else vox_r <= vox_en & ~pdn & (mag_w >= thr_w);
    end
    assign tx_voice_detect_out = vox_r;
    assign status_w = {vox_r, 7'h00};
    logic [2:0] tone_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) tone_r <= 3'h0;
        else tone_r <= tone_sign_in & switch_r[2:0];
    end
    assign tone_sign_outputs = tone_r;

    // ==========================================================
    // Assertions
    a_pdn_release: assert property (@(posedge hclk) disable iff (!hresetn)
        pdn |-> !adpcm_tx_oe) else $error("adpcm driven in power-down");
    a_pdn_or: assert property (@(posedge hclk) disable iff (!hresetn)
        !codec_powerdown_pin |-> codec_powered_down) else $error("pin power-down ignored");
    a_pdn_reg: assert property (@(posedge hclk) disable iff (!hresetn)
        power_r[`BIT_PDN_ALL] |-> codec_powered_down) else $error("bit power-down ignored");
    a_reg_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        reg_clear |=> (voice_r == 8'h00 && power_r == 8'h00)) else $error("regs not cleared");
    a_vox_status: assert property (@(posedge hclk) disable iff (!hresetn)
        status_w[7] == tx_voice_detect_out) else $error("status mismatch");
    a_vox_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        !$past(vox_en) |-> !tx_voice_detect_out) else $error("vox without enable");
    a_tx_msb: assert property (@(posedge hclk) disable iff (!hresetn)
        (sck_rise && q_w.tx_sync && !pdn) |=> tx_pcm_out == $past(tx_sample_r[PCM_W-1]))
        else $error("tx msb wrong");
    a_noise_sel: assert property (@(posedge hclk) disable iff (!hresetn)
        (vox_en && voice_r[`BIT_VOX_IN]) |-> !rx_noise_select) else $error("flag or lost");
    a_tone_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        (switch_r[2:0] == 3'h0) |=> tone_sign_outputs == 3'h0) else $error("tone ungated");
    c_tx_frame: cover property (@(posedge hclk) sck_rise && q_w.tx_sync && !pdn);
    c_rx_frame: cover property (@(posedge hclk) sck_fall && q_w.rx_sync && !pdn);
    c_noise: cover property (@(posedge hclk) rx_noise_select);
endmodule // vox_codec_serial

// [inc/vox_codec_params.svh]
`ifndef VOX_CODEC_PARAMS_SVH
`define VOX_CODEC_PARAMS_SVH
// Register byte offsets
`define OFS_POWER 8'h00
`define OFS_CODEC_MODE 8'h04
`define OFS_SWITCH 8'h14
`define OFS_VOICE 8'h18
`define OFS_STATUS 8'h1C
`define OFS_TX_SAMPLE 8'h20
`define OFS_RX_RESULT 8'h24
// Field positions
`define BIT_PDN_ALL 5
`define BIT_VOX_EN 7
`define BIT_VOX_IN 3
`define BIT_VOX_LVL_HI 6
`define BIT_VOX_LVL_LO 5
`define BIT_VOX_OUT 7
`define BIT_MODE_HI 7
`define BIT_MODE_LO 6
// Word lengths
`define PCM_BITS 4'h8
`define ADPCM_BITS_32K 4'h4
`define ADPCM_BITS_24K 4'h3
`define ADPCM_BITS_16K 4'h2
// Reset values
`define REG_RESET 8'h00
`define WORD_RESET 32'h0000_0000
// Reset pin minimum low time
`define REG_RESET_MIN_NS 200
`define CLK_PERIOD_NS 25
`define REG_RESET_CYCLES (((`REG_RESET_MIN_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
// Energy thresholds per level selection
`define VOX_THR_0 8'h10
`define VOX_THR_1 8'h20
`define VOX_THR_2 8'h30
`define VOX_THR_3 8'h40
`endif

// [inc/vox_codec_pkg.sv]
package vox_codec_pkg;
    // Synchronised serial pins
    typedef struct packed {
        logic shift_clk;
        logic tx_sync;
        logic rx_sync;
        logic tx_pcm;
        logic rx_pcm;
        logic adpcm_rx;
    } serial_in_s;
    typedef enum logic [1:0] {
        ADPCM_32K,
        ADPCM_24K,
        ADPCM_16K,
        ADPCM_RSVD
    } adpcm_rate_e;
endpackage

// [testbench/vox_baseband_model.sv]
`timescale 1ns/10ps
// ============================================================
// Baseband controller model on the serial side
module vox_baseband_model (
    output logic shift_clk,
    output logic tx_frame_sync,
    output logic rx_frame_sync,
    output logic tx_pcm_in,
    output logic rx_pcm_in,
    output logic adpcm_rx_in,
    input wire logic tx_pcm_out,
    input wire logic rx_pcm_out,
    input wire logic adpcm_wire
);
    logic [7:0] tx_word, ad_word, rxo_word;
    assign tx_pcm_in = tx_pcm_out;
    initial begin
        shift_clk = 1'b0;
        tx_frame_sync = 1'b0;
        rx_frame_sync = 1'b0;
        rx_pcm_in = 1'b0;
        adpcm_rx_in = 1'b0;
    end
    // One word each way; clock stands low outside the frame
    task automatic frame(input logic [7:0] rx_word, input logic [3:0] code);
        for (int i = 0; i <= 8; i++) begin
            #50;
            if (i > 0) begin
                tx_word[8 - i] = tx_pcm_out;
                ad_word[8 - i] = adpcm_wire;
                rxo_word[8 - i] = rx_pcm_out;
            end
            if (i < 8) begin
                tx_frame_sync = (i == 0);
                rx_frame_sync = (i == 0);
                rx_pcm_in = rx_word[7 - i];
                adpcm_rx_in = (i < 4) ? code[3 - i] : ~adpcm_rx_in;
                #50 shift_clk = 1'b1;
                #100 shift_clk = 1'b0;
            end
        end
        tx_frame_sync = 1'b0;
        rx_frame_sync = 1'b0;
        rx_pcm_in = ~rx_pcm_in;
        adpcm_rx_in = ~adpcm_rx_in;
    endtask
endmodule // vox_baseband_model

// [testbench/vox_codec_serial_test.sv]
`timescale 1ns/10ps
// ============================================================
// Top-level bench
module vox_codec_serial_test;
    logic hclk, hresetn, hsel, hwrite, hready, reg_reset_n, pdn_pin, voice_flag;
    logic [31:0] haddr, hwdata, hrdata, obs, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, tone_in, tone_out;
    logic hreadyout, hresp, txo, rxo, ad_out, ad_oe, vox_out, pd, noise;
    logic sclk, txs, rxs, txi, rxi, adi;
    logic [7:0] v, e8;
    int failures, n_compared;
    logic [31:0] exp_q[$];
    string nm_q[$];
    event got;
    wire ad_wire = ad_oe ? ad_out : 1'b1;
    assign hready = hreadyout;
    vox_codec_serial vox_codec_serial_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .reg_reset_n(reg_reset_n), .codec_powerdown_pin(pdn_pin), .shift_clk(sclk),
        .tx_frame_sync(txs), .rx_frame_sync(rxs), .tx_pcm_in(txi), .rx_pcm_in(rxi),
        .adpcm_rx_in(adi), .rx_voice_flag_in(voice_flag), .tone_sign_in(tone_in),
        .tx_pcm_out(txo), .rx_pcm_out(rxo), .adpcm_tx_out(ad_out), .adpcm_tx_oe(ad_oe),
        .tx_voice_detect_out(vox_out), .tone_sign_outputs(tone_out),
        .codec_powered_down(pd), .rx_noise_select(noise));
    vox_baseband_model vox_baseband_model_inst (.shift_clk(sclk), .tx_frame_sync(txs),
        .rx_frame_sync(rxs), .tx_pcm_in(txi), .rx_pcm_in(rxi), .adpcm_rx_in(adi),
        .tx_pcm_out(txo), .rx_pcm_out(rxo), .adpcm_wire(ad_wire));
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // ============================================================
    // Result checking
    task automatic summarize();
        $display("Compared %0d, mismatched %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        exp_q.push_back(e);
        nm_q.push_back(nm);
        obs = s;
        ->got;
        #1;
    endtask
    initial begin
        forever begin
            @(got);
            cmp(nm_q.pop_front(), exp_q.pop_front(), obs);
        end
    end
    // ============================================================
    // Bus and serial helpers
    task automatic wait_ready();
        int n = 0;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) begin
                failures++;
                summarize();
            end
            @(posedge hclk);
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'b010;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic run(input logic [7:0] w, input logic [3:0] c);
        @(posedge hclk);
        #7;
        vox_baseband_model_inst.frame(w, c);
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge hclk);
    endtask
    initial begin
        #2000000;
        failures++;
        summarize();
    end
    // ============================================================
    // Main sequence
    initial begin
        hresetn = 1'b0;
        reg_reset_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        pdn_pin = 1'b1;
        voice_flag = 1'b0;
        tone_in = 3'b000;
        void'($urandom(27));
        ticks(8);
        hresetn <= 1'b1;
        ticks(12);
        reg_reset_n <= 1'b1;
        ticks(6);
        ahb(1'b1, 32'h0000_003C, 32'h0000_00FF);
        ahb(1'b0, 32'h0000_003C, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd);
        chk("hresp", 32'h0000_0000, hresp);
        ahb(1'b1, 32'h0000_0000, 32'h0000_0020);
        ticks(2);
        chk("pd_by_reg", 32'h0000_0001, pd);
        reg_reset_n <= 1'b0;
        ticks(10);
        reg_reset_n <= 1'b1;
        ticks(6);
        ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
        chk("power_reg", 32'h0000_0000, rd);
        chk("pd_clear", 32'h0000_0000, pd);
        pdn_pin <= 1'b0;
        ticks(6);
        chk("pd_by_pin", 32'h0000_0001, pd);
        run(8'hA5, 4'h3);
        run(8'hA5, 4'h3);
        chk("adpcm_released", 32'h0000_00FF, vox_baseband_model_inst.ad_word);
        pdn_pin <= 1'b1;
        ticks(6);
        for (int m = 2; m >= 0; m--) begin
            v = $urandom;
            e8 = 8'hFF >> (4 - m);
            ahb(1'b1, 32'h0000_0004, 32'(m) << 6);
            ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
            chk("mode_reg", 32'(m) << 6, rd);
            ahb(1'b1, 32'h0000_0020, {24'h0, v});
            run(8'h00, 4'h0);
            run(8'h00, 4'h0);
            chk("tx_pcm", {24'h0, v}, vox_baseband_model_inst.tx_word);
            chk("adpcm_tx", {24'h0, (v & ~e8) | e8}, vox_baseband_model_inst.ad_word);
        end
        v = $urandom;
        run(v, v[3:0]);
        run(v, v[3:0]);
        ahb(1'b0, 32'h0000_0024, 32'h0000_0000);
        chk("rx_pcm_in", {24'h0, v}, rd);
        chk("rx_pcm_out", {28'h0, v[3:0]}, vox_baseband_model_inst.rxo_word >> 4);
        for (int k = 0; k < 8; k++) begin
            v = {k[2], 2'($urandom), 1'b0, k[1], 3'b000};
            voice_flag <= k[0];
            ahb(1'b1, 32'h0000_0018, {24'h0, v});
            ahb(1'b0, 32'h0000_0018, 32'h0000_0000);
            chk("voice_reg", {24'h0, v}, rd);
            ticks(6);
            chk("noise_sel", {31'h0, k[2] & ~(k[1] | k[0])}, noise);
            if (!k[2]) chk("vox_gated", 32'h0000_0000, vox_out);
            ahb(1'b0, 32'h0000_001C, 32'h0000_0000);
            chk("status_voice", {31'h0, vox_out}, rd[7]);
        end
        for (int t = 0; t < 8; t++) begin
            tone_in <= 3'($urandom);
            ahb(1'b1, 32'h0000_0014, 32'(t));
            ticks(4);
            chk("tone_sign", {29'h0, tone_in & 3'(t)}, tone_out);
        end
        ticks(4);
        summarize();
    end
endmodule // vox_codec_serial_test
